/* File: bench/fobc_host.sv */
// fobc_host: host end of the boot download link
// assumes idle-high pulled-up lines and a device that answers after measuring
`timescale 1ns/1ps
module fobc_host #(
    parameter int BIT = 90
)(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       txd,
    output logic            rxd,
    output logic [7:0]      got
);
    logic [7:0] msg [5] = '{8'h55, 8'h00, 8'h02, 8'ha5, 8'h3c};
    // start bit and eight data bits lsb first, line left high for stop
    task automatic put(input logic [7:0] b);
        rxd <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            rxd <= b[i];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask : put
    initial
    begin
        rxd = 1'b1;
        got = 8'hff;
        wait (go);
        repeat (4 * BIT) @(posedge clk);
        put(8'h00);
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT + 1) @(posedge clk);
            got[i] = txd;
        end
        repeat (2 * BIT) @(posedge clk);
        foreach (msg[i])
        begin
            put(msg[i]);
            repeat (BIT) @(posedge clk);
        end
    end
endmodule : fobc_host

/* File: bench/testbench.sv */
// testbench: boot download, overlay, error flag and interrupt checks
// assumes fobc_top with zero-wait ahb-lite slave and fobc_host on the link
`timescale 1ns/1ps
`include "fobc_map.svh"
module testbench;
    logic        CLK_SYS, RESETN, HSEL, HWRITE, MODE_PIN_2, MODE_PIN_1, MODE_PIN_0;
    logic        MODE_PIN_2_HV, VPP_HV, RXD, HW_STANDBY, PE_ACTIVE, FLASH_RD, EXC_SEQ;
    logic        EXC_EXCLUDED, SLEEP_EXEC, BUS_RELEASE, HREADYOUT, HRESP, TXD;
    logic        ERR_PROTECT, WR_PROTECT, OVL_HIT, BOOT_MODE, BRANCH, IRQ, HREADY, go;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE, OP_MODE;
    logic [7:0]  PRAM_RDATA, host_got;
    logic [11:0] PRAM_RADDR;
    logic [23:0] FLASH_RD_ADDR, RAM_BASE, BAUD_DIV, BRANCH_ADDR;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    int          bad_count = 0;
    int          samples_checked = 0;
    assign HREADY = HREADYOUT;
    fobc_top i_dut (.*);
    fobc_host i_host (.clk(CLK_SYS), .go(go), .txd(TXD), .rxd(RXD), .got(host_got));
    initial
    begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end
    task automatic close_out;
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // one single word transfer, read data left in rd
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        do @(posedge CLK_SYS); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge CLK_SYS); while (HREADY !== 1'b1);
        rd = HRDATA;
        chk("hresp", 32'h0, {31'h0, HRESP});
    endtask : bus
    task automatic rst(input logic hv, input logic [1:0] m);
        RESETN <= 1'b0;
        {MODE_PIN_2_HV, VPP_HV, MODE_PIN_1, MODE_PIN_0} <= {hv, hv, m};
        repeat (16) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        chk("boot_mode", {31'h0, hv}, {31'h0, BOOT_MODE});
        chk("op_mode", (m != 2'b00) ? 32'h4 + m : 32'h0, {29'h0, OP_MODE});
    endtask : rst
    // one event pulse: 0 read, 1 exception, 2 sleep, 3 release, 4 excluded, 5 overlay read
    task automatic evt(input int k);
        FLASH_RD_ADDR <= (k == 5) ? 24'h01f100 : 24'h000100;
        {FLASH_RD, EXC_SEQ, EXC_EXCLUDED, SLEEP_EXEC, BUS_RELEASE} <=
            {k == 0 || k == 5, k == 1 || k == 4, k == 4, k == 2, k == 3};
        @(posedge CLK_SYS);
        {FLASH_RD, EXC_SEQ, EXC_EXCLUDED, SLEEP_EXEC, BUS_RELEASE} <= 5'h0;
        @(posedge CLK_SYS);
        chk("ovl_hit", {31'h0, k == 5}, {31'h0, OVL_HIT});
        repeat (2) @(posedge CLK_SYS);
    endtask : evt
    initial
    begin
        {RESETN, HSEL, HWRITE, HTRANS, HADDR, HWDATA, PRAM_RADDR, FLASH_RD_ADDR} = '0;
        {MODE_PIN_2_HV, VPP_HV, MODE_PIN_1, MODE_PIN_0, HW_STANDBY, PE_ACTIVE} = '0;
        {FLASH_RD, EXC_SEQ, EXC_EXCLUDED, SLEEP_EXEC, BUS_RELEASE, go} = '0;
        HSIZE = 3'b010;
        MODE_PIN_2 = 1'b1;
        rst(1'b1, 2'b11);
        go <= 1'b1;
        for (int i = 0; i < 30000 && BRANCH !== 1'b1; i++) @(posedge CLK_SYS);
        chk("branch", 32'h1, {31'h0, BRANCH});
        chk("branch_addr", 32'h00fff300, {8'h0, BRANCH_ADDR});
        chk("host_got", 32'h0, {24'h0, host_got});
        chk("baud_ok", 32'h1, {31'h0, BAUD_DIV >= 24'd89 && BAUD_DIV <= 24'd90});
        for (int i = 0; i < 2; i++)
        begin
            PRAM_RADDR <= 12'(i);
            repeat (2) @(posedge CLK_SYS);
            chk("pram", (i == 1) ? 32'h3c : 32'ha5, {24'h0, PRAM_RDATA});
        end
        for (int k = 0; k < 8; k++)
        begin
            bus(`FOBC_OFS_CTRL, 1'b1, 32'h88 | k);
            bus(`FOBC_OFS_CTRL, 1'b0, 32'h0);
            chk("ctrl", 32'h78 | k, rd);
            chk("ram_base", 32'h01f000 + 32'h200 * k, {8'h0, RAM_BASE});
            chk("wr_protect", 32'h1, {31'h0, WR_PROTECT});
        end
        bus(`FOBC_OFS_CTRL, 1'b1, 32'h0);
        bus(8'h40, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("ram_base", 32'hfff000, {8'h0, RAM_BASE});
        chk("wr_protect", 32'h0, {31'h0, WR_PROTECT});
        bus(`FOBC_OFS_MASK, 1'b1, 32'h1);
        PE_ACTIVE <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            bus(`FOBC_OFS_CTRL, 1'b1, 32'h8);
            evt(k);
            bus(`FOBC_OFS_CTRL, 1'b0, 32'h0);
            chk("ctrl", (k < 4) ? 32'hf8 : 32'h78, rd);
            chk("err_protect", {31'h0, k < 4}, {31'h0, ERR_PROTECT});
            chk("irq", {31'h0, k < 4}, {31'h0, IRQ});
            bus(`FOBC_OFS_STATUS, 1'b1, 32'h1);
            HW_STANDBY <= 1'b1;
            @(posedge CLK_SYS);
            HW_STANDBY <= 1'b0;
            bus(`FOBC_OFS_CTRL, 1'b0, 32'h0);
            chk("ctrl", 32'h70, rd);
            chk("irq", 32'h0, {31'h0, IRQ});
        end
        bus(`FOBC_OFS_MASK, 1'b1, 32'h0);
        evt(2);
        bus(`FOBC_OFS_STATUS, 1'b0, 32'h0);
        chk("status", 32'h3, rd);
        chk("irq", 32'h0, {31'h0, IRQ});
        PE_ACTIVE <= 1'b0;
        rst(1'b0, 2'b00);
        bus(`FOBC_OFS_CTRL, 1'b1, 32'hf);
        bus(`FOBC_OFS_CTRL, 1'b0, 32'h0);
        chk("ctrl", 32'h70, rd);
        rst(1'b0, 2'b01);
        bus(`FOBC_OFS_CTRL, 1'b1, 32'hf);
        bus(`FOBC_OFS_CTRL, 1'b0, 32'h0);
        chk("ctrl", 32'h7f, rd);
        chk("branch_addr", 32'h000ff300, {8'h0, BRANCH_ADDR});
        bus(`FOBC_OFS_LOADER, 1'b0, 32'h0);
        chk("loader", 32'h50, rd);
        close_out;
    end
    initial
    begin
        repeat (50000) @(posedge CLK_SYS);
        bad_count++;
        close_out;
    end
endmodule : testbench

/* File: include/fobc_map.svh */
// fobc_map.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the overlay/boot control block
`ifndef FOBC_MAP_SVH
`define FOBC_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FOBC_OFS_CTRL      8'h00
`define FOBC_OFS_STATUS    8'h04
`define FOBC_OFS_MASK      8'h08
`define FOBC_OFS_BAUD      8'h0c
`define FOBC_OFS_LOADER    8'h10
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FOBC_BIT_ERR       7
`define FOBC_BIT_SEL       3
`define FOBC_CTRL_RSVD     3'h7
`define FOBC_CTRL_RESET    8'h70
`define FOBC_ST_ERR        0
`define FOBC_ST_DONE       1
`define FOBC_ST_FAIL       2
`define FOBC_ST_W          3
// ----------------------------------------------------------------
// address map and boot constants
// ----------------------------------------------------------------
`define FOBC_RAM_HOME      24'hfff000
`define FOBC_OVL_BASE      24'h01f000
`define FOBC_BLK_SIZE      24'h000200
`define FOBC_BRANCH_56     24'h0ff300
`define FOBC_BRANCH_7      24'hfff300
`define FOBC_BYTE_ALIGNED  8'h00
`define FOBC_BYTE_ACK      8'h55
`define FOBC_LOW_BITS      9
`define FOBC_PRAM_BYTES    3072
`define FOBC_SETUP_STATES  100
`endif

/* File: include/fobc_pkg.sv */
// fobc_pkg: types of the overlay/boot control block
// assumes fobc_map.svh constants alongside
package fobc_pkg;
    typedef enum logic [3:0] {
        LD_OFF, LD_SETUP, LD_WAITHI, LD_WAITLO, LD_MEAS, LD_TX,
        LD_RXWAIT, LD_RXBIT, LD_DONE, LD_FAIL
    } fobc_ld_state_t;
endpackage : fobc_pkg

/* File: rtl/fobc_top.sv */
// fobc_top: flash error flag, ram overlay, mode decode and boot loader
// assumes ahb-lite master on CLK_SYS; cpu-side strobes on CLK_SYS; pins async
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "fobc_map.svh"
module fobc_top
    import fobc_pkg::*;
#(
    parameter int CW = 24
)(
    input  wire logic        CLK_SYS,
    input  wire logic        RESETN,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic      [31:0] HRDATA,
    output logic             HRESP,
    input  wire logic        MODE_PIN_2,
    input  wire logic        MODE_PIN_1,
    input  wire logic        MODE_PIN_0,
    input  wire logic        MODE_PIN_2_HV,
    input  wire logic        VPP_HV,
    input  wire logic        RXD,
    output logic             TXD,
    input  wire logic        HW_STANDBY,
    input  wire logic        PE_ACTIVE,
    input  wire logic        FLASH_RD,
    input  wire logic [23:0] FLASH_RD_ADDR,
    input  wire logic        EXC_SEQ,
    input  wire logic        EXC_EXCLUDED,
    input  wire logic        SLEEP_EXEC,
    input  wire logic        BUS_RELEASE,
    input  wire logic [11:0] PRAM_RADDR,
    output logic      [7:0]  PRAM_RDATA,
    output logic             ERR_PROTECT,
    output logic             WR_PROTECT,
    output logic             OVL_HIT,
    output logic      [23:0] RAM_BASE,
    output logic             BOOT_MODE,
    output logic      [2:0]  OP_MODE,
    output logic      [CW-1:0] BAUD_DIV,
    output logic             BRANCH,
    output logic      [23:0] BRANCH_ADDR,
    output logic             IRQ
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [23:0] ovl_addr(input logic sel, input logic [2:0] blk);
        ovl_addr = sel ? (`FOBC_OVL_BASE + (`FOBC_BLK_SIZE * {21'h0, blk}))
                       : `FOBC_RAM_HOME;
    endfunction : ovl_addr

    logic [2:0] pin_s1_reg, pin_s2_reg, hv_s1_reg, hv_s2_reg;
    logic       rst_d_reg, flash_en_reg;
    logic       err_reg, sel_reg;
    logic [2:0] blk_reg;
    logic [`FOBC_ST_W-1:0] status_reg, mask_reg, ev;
    logic       wr_ph_reg;
    logic [7:0] wa_reg;
    logic       done_ev, fail_ev;
    logic       ovl_hit_now, err_set;
    logic [7:0] ctrl_rd;
    logic [23:0] ovl_base_now;
    fobc_ld_state_t ld_state;

    // ----------------------------------------------------------------
    // pin synchronisers and mode latch at reset release
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        pin_s1_reg <= {MODE_PIN_2, MODE_PIN_1, MODE_PIN_0};
        pin_s2_reg <= pin_s1_reg;
        hv_s1_reg  <= {MODE_PIN_2_HV, VPP_HV, RXD};
        hv_s2_reg  <= hv_s1_reg;
    end

    always_ff @(posedge CLK_SYS)
    begin
        rst_d_reg <= RESETN;
        if (!RESETN)
        begin
            BOOT_MODE    <= 1'b0;
            OP_MODE      <= 3'h0;
            flash_en_reg <= 1'b0;
        end
        else if (!rst_d_reg)
        begin
            BOOT_MODE    <= hv_s2_reg[2] & hv_s2_reg[1] & (pin_s2_reg[1:0] != 2'b00);
            OP_MODE      <= (pin_s2_reg[1:0] == 2'b00) ? 3'h0 : {1'b1, pin_s2_reg[1:0]};
            flash_en_reg <= (pin_s2_reg[2] | hv_s2_reg[2]) & (pin_s2_reg[1:0] != 2'b00);
        end
    end

    // ----------------------------------------------------------------
    // flash error flag
    // ----------------------------------------------------------------
    assign ovl_base_now = ovl_addr(1'b1, blk_reg);
    assign ovl_hit_now  = sel_reg && (FLASH_RD_ADDR[23:9] == ovl_base_now[23:9]);
    assign err_set = PE_ACTIVE & ((FLASH_RD & ~ovl_hit_now)
                                | (EXC_SEQ & ~EXC_EXCLUDED)
                                | SLEEP_EXEC
                                | BUS_RELEASE);

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN || HW_STANDBY)
            err_reg <= 1'b0;
        else if (err_set)
            err_reg <= 1'b1;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            ERR_PROTECT <= 1'b0;
            WR_PROTECT  <= 1'b0;
            OVL_HIT     <= 1'b0;
            RAM_BASE    <= `FOBC_RAM_HOME;
        end
        else
        begin
            ERR_PROTECT <= err_reg;
            WR_PROTECT  <= err_reg | sel_reg;
            OVL_HIT     <= FLASH_RD & ovl_hit_now;
            RAM_BASE    <= ovl_addr(sel_reg, blk_reg);
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    assign ctrl_rd = {err_reg, `FOBC_CTRL_RSVD, sel_reg, blk_reg};

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            wr_ph_reg <= 1'b0;
            wa_reg    <= 8'h00;
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
        else if (HREADY)
        begin
            wr_ph_reg <= HSEL & HTRANS[1] & HWRITE;
            wa_reg    <= HADDR[7:0];
            HRDATA    <= 32'h0000_0000;
            if (HSEL && HTRANS[1] && !HWRITE)
            begin
                case (HADDR[7:0])
                    `FOBC_OFS_CTRL:   HRDATA <= {24'h0, ctrl_rd};
                    `FOBC_OFS_STATUS: HRDATA <= {29'h0, status_reg};
                    `FOBC_OFS_MASK:   HRDATA <= {29'h0, mask_reg};
                    `FOBC_OFS_BAUD:   HRDATA <= 32'(BAUD_DIV);
                    `FOBC_OFS_LOADER: HRDATA <= {24'h0, BOOT_MODE, OP_MODE, 4'(ld_state)};
                    default:          HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN || HW_STANDBY)
        begin
            sel_reg <= 1'b0;
            blk_reg <= 3'h0;
        end
        else if (wr_ph_reg && wa_reg == `FOBC_OFS_CTRL && flash_en_reg)
        begin
            sel_reg <= HWDATA[`FOBC_BIT_SEL];
            blk_reg <= HWDATA[2:0];
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, mask and output
    // ----------------------------------------------------------------
    assign ev = {fail_ev, done_ev, err_set & ~err_reg};

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            status_reg <= '0;
            mask_reg   <= '0;
            IRQ        <= 1'b0;
        end
        else
        begin
            if (wr_ph_reg && wa_reg == `FOBC_OFS_STATUS)
                status_reg <= (status_reg & ~HWDATA[`FOBC_ST_W-1:0]) | ev;
            else
                status_reg <= status_reg | ev;
            if (wr_ph_reg && wa_reg == `FOBC_OFS_MASK)
                mask_reg <= HWDATA[`FOBC_ST_W-1:0];
            IRQ <= |(status_reg & mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // boot loader: bit-rate measure, sync exchange, download
    // ----------------------------------------------------------------
    logic [CW-1:0]  cnt_reg, sub_reg;
    logic [3:0]     bit_reg;
    logic [9:0]     tx_sh_reg;
    logic [7:0]     rx_sh_reg;
    logic [1:0]     phase_reg;
    logic [11:0]    len_reg, wr_idx_reg;
    logic [7:0]     pram [`FOBC_PRAM_BYTES];
    logic           rx_s;

    assign rx_s    = hv_s2_reg[0];
    assign done_ev = (ld_state == LD_RXBIT) && (bit_reg == 4'd9) && (cnt_reg == '0)
                     && (phase_reg == 2'd3) && (wr_idx_reg + 12'd1 >= len_reg);
    assign fail_ev = (ld_state == LD_RXBIT) && (bit_reg == 4'd9) && (cnt_reg == '0)
                     && (phase_reg == 2'd0) && (rx_sh_reg != `FOBC_BYTE_ACK);

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            ld_state   <= LD_OFF;
            cnt_reg    <= '0;
            sub_reg    <= '0;
            bit_reg    <= 4'h0;
            tx_sh_reg  <= 10'h3ff;
            rx_sh_reg  <= 8'h00;
            phase_reg  <= 2'd0;
            len_reg    <= 12'h000;
            wr_idx_reg <= 12'h000;
            BAUD_DIV   <= '0;
            TXD        <= 1'b1;
            BRANCH     <= 1'b0;
        end
        else
        begin
            BRANCH <= 1'b0;
            case (ld_state)
                LD_OFF:
                    if (!rst_d_reg)
                    begin
                        ld_state <= LD_SETUP;
                        cnt_reg  <= CW'(`FOBC_SETUP_STATES);
                    end
                    else if (BOOT_MODE)
                        ld_state <= LD_SETUP;
                LD_SETUP:
                    if (!BOOT_MODE)
                        ld_state <= LD_OFF;
                    else if (cnt_reg == '0)
                        ld_state <= LD_WAITHI;
                    else
                        cnt_reg <= cnt_reg - CW'(1);
                LD_WAITHI:
                    if (rx_s)
                        ld_state <= LD_WAITLO;
                LD_WAITLO:
                    if (!rx_s)
                    begin
                        ld_state <= LD_MEAS;
                        cnt_reg  <= '0;
                        sub_reg  <= '0;
                    end
                LD_MEAS:
                    if (rx_s)
                    begin
                        BAUD_DIV <= cnt_reg;
                        tx_sh_reg <= {1'b1, `FOBC_BYTE_ALIGNED, 1'b0};
                        bit_reg  <= 4'h0;
                        sub_reg  <= cnt_reg;
                        ld_state <= LD_TX;
                    end
                    else if (sub_reg == CW'(`FOBC_LOW_BITS - 1))
                    begin
                        sub_reg <= '0;
                        cnt_reg <= cnt_reg + CW'(1);
                    end
                    else
                        sub_reg <= sub_reg + CW'(1);
                LD_TX:
                begin
                    TXD <= tx_sh_reg[0];
                    if (sub_reg == '0)
                    begin
                        sub_reg   <= BAUD_DIV;
                        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
                        bit_reg   <= bit_reg + 4'h1;
                        if (bit_reg == 4'd9)
                            ld_state <= LD_RXWAIT;
                    end
                    else
                        sub_reg <= sub_reg - CW'(1);
                end
                LD_RXWAIT:
                begin
                    TXD <= 1'b1;
                    if (!rx_s)
                    begin
                        cnt_reg  <= BAUD_DIV >> 1;
                        bit_reg  <= 4'h0;
                        ld_state <= LD_RXBIT;
                    end
                end
                LD_RXBIT:
                    if (cnt_reg != '0)
                        cnt_reg <= cnt_reg - CW'(1);
                    else if (bit_reg == 4'd9)
                    begin
                        ld_state <= LD_RXWAIT;
                        case (phase_reg)
                            2'd0:
                                if (rx_sh_reg == `FOBC_BYTE_ACK)
                                    phase_reg <= 2'd1;
                                else
                                    ld_state <= LD_FAIL;
                            2'd1:
                            begin
                                len_reg   <= {rx_sh_reg[3:0], 8'h00};
                                phase_reg <= 2'd2;
                            end
                            2'd2:
                            begin
                                len_reg    <= {len_reg[11:8], rx_sh_reg};
                                wr_idx_reg <= 12'h000;
                                phase_reg  <= 2'd3;
                                if ({len_reg[11:8], rx_sh_reg} == 12'h000)
                                    ld_state <= LD_DONE;
                            end
                            default:
                            begin
                                wr_idx_reg <= wr_idx_reg + 12'd1;
                                if (wr_idx_reg + 12'd1 >= len_reg)
                                    ld_state <= LD_DONE;
                            end
                        endcase
                    end
                    else
                    begin
                        cnt_reg <= BAUD_DIV;
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg != 4'h0)
                            rx_sh_reg <= {rx_s, rx_sh_reg[7:1]};
                    end
                LD_DONE:
                    if (!BRANCH && phase_reg == 2'd3)
                    begin
                        BRANCH    <= 1'b1;
                        phase_reg <= 2'd0;
                    end
                LD_FAIL:
                    ld_state <= LD_FAIL;
                default:
                    ld_state <= LD_OFF;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
            BRANCH_ADDR <= 24'h000000;
        else
            BRANCH_ADDR <= (OP_MODE == 3'd7) ? `FOBC_BRANCH_7 : `FOBC_BRANCH_56;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (ld_state == LD_RXBIT && cnt_reg == '0 && bit_reg == 4'd9 &&
            phase_reg == 2'd3 && wr_idx_reg < 12'(`FOBC_PRAM_BYTES))
            pram[wr_idx_reg] <= rx_sh_reg;
        PRAM_RDATA <= pram[PRAM_RADDR];
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_read_err;
        @(posedge CLK_SYS) disable iff (!RESETN)
        (PE_ACTIVE && FLASH_RD && !ovl_hit_now && !HW_STANDBY) |=> err_reg;
    endproperty
    a_read_err: assert property (p_read_err) else $error("flash read did not set error");

    property p_ovl_noerr;
        @(posedge CLK_SYS) disable iff (!RESETN)
        (!err_reg && PE_ACTIVE && FLASH_RD && ovl_hit_now && !EXC_SEQ && !SLEEP_EXEC
         && !BUS_RELEASE) |=> !err_reg;
    endproperty
    a_ovl_noerr: assert property (p_ovl_noerr) else $error("overlay read set error");

    property p_exc_err;
        @(posedge CLK_SYS) disable iff (!RESETN)
        (PE_ACTIVE && EXC_SEQ && !EXC_EXCLUDED && !HW_STANDBY) |=> err_reg;
    endproperty
    a_exc_err: assert property (p_exc_err) else $error("exception did not set error");

    property p_sleep_bus;
        @(posedge CLK_SYS) disable iff (!RESETN)
        (PE_ACTIVE && (SLEEP_EXEC || BUS_RELEASE) && !HW_STANDBY) |=> err_reg ##1 ERR_PROTECT;
    endproperty
    a_sleep_bus: assert property (p_sleep_bus) else $error("sleep or release missed");

    property p_protect;
        @(posedge CLK_SYS) disable iff (!RESETN)
        (err_reg || sel_reg) |=> WR_PROTECT;
    endproperty
    a_protect: assert property (p_protect) else $error("protect not raised");

    property p_err_sticky;
        @(posedge CLK_SYS) disable iff (!RESETN)
        (err_reg && !HW_STANDBY) |=> err_reg;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

    property p_rsvd;
        @(posedge CLK_SYS) disable iff (!RESETN)
        (HREADY && HSEL && HTRANS[1] && !HWRITE && HADDR[7:0] == `FOBC_OFS_CTRL)
        |=> HRDATA[6:4] == 3'h7;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");

    property p_mode_lock;
        @(posedge CLK_SYS) disable iff (!RESETN)
        (!flash_en_reg && !$past(HW_STANDBY)) |-> $stable(sel_reg) && $stable(blk_reg);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("overlay written outside 5-7");

    property p_base;
        @(posedge CLK_SYS) disable iff (!RESETN)
        sel_reg ##1 sel_reg |-> RAM_BASE == `FOBC_OVL_BASE + (`FOBC_BLK_SIZE * {21'h0, $past(blk_reg)});
    endproperty
    a_base: assert property (p_base) else $error("overlay base wrong");

endmodule : fobc_top
